// ==== hdl/port_data_pkg.sv ====
package port_data_pkg;

	// Register addresses as printed; the plain port carries full byte addresses
	localparam int                 ADDR_WIDTH             = 28;
	localparam logic [27:0]        FIRST_PORT_DATA_ADDR   = 28'h5ff_ffc0;
	localparam logic [27:0]        SECOND_PORT_DATA_ADDR  = 28'h5ff_ffc2;
	localparam logic [27:0]        FIRST_PORT_DIR_ADDR    = 28'h5ff_ffc4;
	localparam logic [27:0]        SECOND_PORT_DIR_ADDR   = 28'h5ff_ffc6;
	localparam logic [27:0]        THIRD_PORT_DATA_ADDR   = 28'h5ff_ffd0;
	localparam logic [27:0]        FIRST_PORT_FUNC_ADDR   = 28'h5ff_ffe0;
	localparam logic [27:0]        SECOND_PORT_FUNC_ADDR  = 28'h5ff_ffe2;
	localparam logic [27:0]        SECOND_PORT_TIMER_ADDR = 28'h5ff_ffe4;
	localparam logic [27:0]        THIRD_PORT_ANALOG_ADDR = 28'h5ff_ffe6;

	// Widths and reset values
	localparam int                 WIDE_PORT_PINS         = 16;
	localparam int                 THIRD_PORT_PINS        = 8;
	localparam logic [15:0]        DATA_RESET             = 16'h0000;
	localparam logic [15:0]        DIR_RESET              = 16'h0000;
	localparam logic [15:0]        FUNC_RESET             = 16'h0000;
	localparam logic [15:0]        UNMAPPED_READ          = 16'h0000;

endpackage

// ==== hdl/wide_port_slice.sv ====
`timescale 1ns/1ps

// One 16-bit bidirectional port: data and direction storage and pin drive
module wide_port_slice
	import port_data_pkg::*;
#(
	parameter int PINS = WIDE_PORT_PINS
) (
	input  wire logic            ref_clk_i,
	input  wire logic            reset_i,
	input  wire logic            data_write_i,
	input  wire logic            dir_write_i,
	input  wire logic [PINS-1:0] wdata_i,
	input  wire logic [PINS-1:0] special_func_i,
	input  wire logic [PINS-1:0] write_lock_i,
	input  wire logic [PINS-1:0] pin_level_i,
	output logic      [PINS-1:0] read_value_o,
	output logic      [PINS-1:0] dir_o,
	output logic      [PINS-1:0] pin_out_o,
	output logic      [PINS-1:0] pin_oe_o
);

	logic [PINS-1:0] data;

	// Data store; locked timer-pattern bits keep their value
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			data <= PINS'(DATA_RESET);
		end else if (data_write_i) begin
			data <= (wdata_i & ~write_lock_i) | (data & write_lock_i);
		end
	end

	// Direction bits, 1 selects output
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			dir_o <= PINS'(DIR_RESET);
		end else if (dir_write_i) begin
			dir_o <= wdata_i;
		end
	end

	// Drive only general-purpose output pins; others untouched
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			pin_out_o <= '0;
			pin_oe_o  <= '0;
		end else begin
			pin_out_o <= data;
			pin_oe_o  <= dir_o & ~special_func_i;
		end
	end

	// Output pins read the register, inputs read the pin
	assign read_value_o = (data & dir_o) | (pin_level_i & ~dir_o);

endmodule

// ==== hdl/port_data_registers.sv ====
`timescale 1ns/1ps

// How it works
// - First port data, 16 bits, resets clear
// - Second port data, 16 bits, resets clear
// - Output general pins drive data, read register
// - First port inputs read pin, writes stored
// - Second port special pins undriven, timer rejects
// - Third port read-only, eight pin bits
// - Third port ignores writes, analog reads one
// - Direction bits: 1 output, reset zero
module port_data_registers
	import port_data_pkg::*;
#(
	parameter int PINS   = WIDE_PORT_PINS,
	parameter int C_PINS = THIRD_PORT_PINS
) (
	input  wire logic                  ref_clk_i,
	input  wire logic                  reset_i,
	input  wire logic [ADDR_WIDTH-1:0] addr_i,
	input  wire logic [15:0]           wdata_i,
	input  wire logic                  write_i,
	input  wire logic                  read_i,
	output logic      [15:0]           rdata_o,
	input  wire logic [PINS-1:0]       first_pin_i,
	output logic      [PINS-1:0]       first_pin_o,
	output logic      [PINS-1:0]       first_pin_oe_o,
	input  wire logic [PINS-1:0]       second_pin_i,
	output logic      [PINS-1:0]       second_pin_o,
	output logic      [PINS-1:0]       second_pin_oe_o,
	input  wire logic [C_PINS-1:0]     third_pin_i
);

	logic [PINS-1:0]   first_func;
	logic [PINS-1:0]   second_func;
	logic [PINS-1:0]   second_timer;
	logic [C_PINS-1:0] third_analog;
	logic [PINS-1:0]   first_read;
	logic [PINS-1:0]   second_read;
	logic [PINS-1:0]   first_dir;
	logic [PINS-1:0]   second_dir;
	logic [15:0]       next_rdata;

	// Address match used by every decoder
	function automatic logic hit(input logic [ADDR_WIDTH-1:0] a, input logic [27:0] r);
		return a == r;
	endfunction

	// Function select stores: special function, timer pattern, analog
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			first_func   <= PINS'(FUNC_RESET);
			second_func  <= PINS'(FUNC_RESET);
			second_timer <= PINS'(FUNC_RESET);
			third_analog <= C_PINS'(FUNC_RESET);
		end else if (write_i) begin
			if (hit(addr_i, FIRST_PORT_FUNC_ADDR)) begin
				first_func <= wdata_i[PINS-1:0];
			end
			if (hit(addr_i, SECOND_PORT_FUNC_ADDR)) begin
				second_func <= wdata_i[PINS-1:0];
			end
			if (hit(addr_i, SECOND_PORT_TIMER_ADDR)) begin
				second_timer <= wdata_i[PINS-1:0];
			end
			if (hit(addr_i, THIRD_PORT_ANALOG_ADDR)) begin
				third_analog <= wdata_i[C_PINS-1:0];
			end
		end
	end

	// First port: writes always stored
	wide_port_slice #(.PINS(PINS)) first_port (
		.ref_clk_i      (ref_clk_i),
		.reset_i        (reset_i),
		.data_write_i   (write_i && hit(addr_i, FIRST_PORT_DATA_ADDR)),
		.dir_write_i    (write_i && hit(addr_i, FIRST_PORT_DIR_ADDR)),
		.wdata_i        (wdata_i[PINS-1:0]),
		.special_func_i (first_func),
		.write_lock_i   ('0),
		.pin_level_i    (first_pin_i),
		.read_value_o   (first_read),
		.dir_o          (first_dir),
		.pin_out_o      (first_pin_o),
		.pin_oe_o       (first_pin_oe_o)
	);

	// Second port: timer-pattern pins lock their data bits
	wide_port_slice #(.PINS(PINS)) second_port (
		.ref_clk_i      (ref_clk_i),
		.reset_i        (reset_i),
		.data_write_i   (write_i && hit(addr_i, SECOND_PORT_DATA_ADDR)),
		.dir_write_i    (write_i && hit(addr_i, SECOND_PORT_DIR_ADDR)),
		.wdata_i        (wdata_i[PINS-1:0]),
		.special_func_i (second_func | second_timer),
		.write_lock_i   (second_timer),
		.pin_level_i    (second_pin_i),
		.read_value_o   (second_read),
		.dir_o          (second_dir),
		.pin_out_o      (second_pin_o),
		.pin_oe_o       (second_pin_oe_o)
	);

	// Read multiplexer; third port data has no write path at all
	always_comb begin
		next_rdata = UNMAPPED_READ;
		if (hit(addr_i, FIRST_PORT_DATA_ADDR)) begin
			next_rdata = 16'(first_read);
		end else if (hit(addr_i, SECOND_PORT_DATA_ADDR)) begin
			next_rdata = 16'(second_read);
		end else if (hit(addr_i, FIRST_PORT_DIR_ADDR)) begin
			next_rdata = 16'(first_dir);
		end else if (hit(addr_i, SECOND_PORT_DIR_ADDR)) begin
			next_rdata = 16'(second_dir);
		end else if (hit(addr_i, THIRD_PORT_DATA_ADDR)) begin
			next_rdata = 16'(third_pin_i | third_analog);
		end else if (hit(addr_i, FIRST_PORT_FUNC_ADDR)) begin
			next_rdata = 16'(first_func);
		end else if (hit(addr_i, SECOND_PORT_FUNC_ADDR)) begin
			next_rdata = 16'(second_func);
		end else if (hit(addr_i, SECOND_PORT_TIMER_ADDR)) begin
			next_rdata = 16'(second_timer);
		end else if (hit(addr_i, THIRD_PORT_ANALOG_ADDR)) begin
			next_rdata = 16'(third_analog);
		end
	end

	// Read data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			rdata_o <= 16'h0000;
		end else if (read_i) begin
			rdata_o <= next_rdata;
		end else begin
			rdata_o <= 16'h0000;
		end
	end

endmodule

// ==== testbench/pin_partner.sv ====
`timescale 1ns/1ps

// Outside world of one port: undriven pins sit at the board level
module pin_partner (
	input  wire logic [15:0] out_i,
	input  wire logic [15:0] oe_i,
	input  wire logic [15:0] ext_i,
	output logic      [15:0] pin_o
);
	// Driven bits follow the device, the rest follow the board
	assign pin_o = (out_i & oe_i) | (ext_i & ~oe_i);
endmodule

// ==== testbench/port_data_registers_sva.sv ====
`timescale 1ns/1ps

// Port-level relations of bus strobes, read data and pin drive
module port_data_registers_sva
	import port_data_pkg::*;
#(parameter int PINS = WIDE_PORT_PINS, parameter int C_PINS = THIRD_PORT_PINS) (
	input wire logic              ref_clk_i,
	input wire logic              reset_i,
	input wire logic [27:0]       addr_i,
	input wire logic [15:0]       wdata_i,
	input wire logic              write_i,
	input wire logic              read_i,
	input wire logic [15:0]       rdata_o,
	input wire logic [PINS-1:0]   first_pin_i,
	input wire logic [PINS-1:0]   first_pin_o,
	input wire logic [PINS-1:0]   first_pin_oe_o,
	input wire logic [PINS-1:0]   second_pin_i,
	input wire logic [PINS-1:0]   second_pin_o,
	input wire logic [PINS-1:0]   second_pin_oe_o,
	input wire logic [C_PINS-1:0] third_pin_i
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	// Pins leave reset undriven and clear
	reset_clear_a: assert property ($past(reset_i) |->
		(first_pin_oe_o | second_pin_oe_o | first_pin_o | second_pin_o) == 0) else $error("pins not clear");
	pin_hold_a: assert property (!$past(write_i, 2) && !$past(reset_i) |->
		$stable(first_pin_oe_o) && $stable(first_pin_o) && $stable(second_pin_oe_o)) else $error("pin moved");
	a_drive_a: assert property (write_i && addr_i == FIRST_PORT_DATA_ADDR |=> ##1
		((first_pin_o ^ $past(wdata_i, 2)) & first_pin_oe_o) == 0) else $error("first pin wrong");
	b_drive_a: assert property (write_i && addr_i == SECOND_PORT_DATA_ADDR |=> ##1
		((second_pin_o ^ $past(wdata_i, 2)) & second_pin_oe_o) == 0) else $error("second pin wrong");
	a_read_a: assert property (read_i && addr_i == FIRST_PORT_DATA_ADDR && !$past(write_i) |=>
		((rdata_o ^ $past(first_pin_o)) & $past(first_pin_oe_o)) == 0) else $error("first read wrong");
	b_read_a: assert property (read_i && addr_i == SECOND_PORT_DATA_ADDR && !$past(write_i) |=>
		((rdata_o ^ $past(second_pin_o)) & $past(second_pin_oe_o)) == 0) else $error("second read wrong");
	c_read_a: assert property (read_i && addr_i == THIRD_PORT_DATA_ADDR |=> rdata_o[15:8] == 0 &&
		(rdata_o[7:0] & $past(third_pin_i)) == $past(third_pin_i)) else $error("third read wrong");
	c_write_a: assert property (write_i && addr_i == THIRD_PORT_DATA_ADDR |=> ##1
		$stable(first_pin_o) && $stable(second_pin_o)) else $error("third write moved a pin");
	cover property (write_i && addr_i == SECOND_PORT_DATA_ADDR ##2 second_pin_oe_o != 0);
	cover property (read_i && addr_i == THIRD_PORT_DATA_ADDR ##1 rdata_o != 0);
	cover property ($fell(reset_i));
endmodule

bind port_data_registers port_data_registers_sva #(.PINS(PINS), .C_PINS(C_PINS)) u_sva (
	.ref_clk_i, .reset_i, .addr_i, .wdata_i, .write_i, .read_i, .rdata_o, .first_pin_i,
	.first_pin_o, .first_pin_oe_o, .second_pin_i, .second_pin_o, .second_pin_oe_o, .third_pin_i);

// ==== testbench/test_port_data_registers.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
	$display("unexpected at %0t got %h expected %h", $time, (g), (e)); end end

module test_port_data_registers;
	typedef struct {logic wr; logic [7:0] a; logic [15:0] d; logic [15:0] x;} row_type;
	logic        ref_clk_i = 0;
	logic        reset_i   = 1;
	logic        write_i   = 0;
	logic        read_i    = 0;
	logic [27:0] addr_i    = 0;
	logic [15:0] wdata_i   = 0;
	logic [15:0] rdata_o, first_pin_i, first_pin_o, first_pin_oe_o;
	logic [15:0] second_pin_i, second_pin_o, second_pin_oe_o;
	logic [7:0]  third_pin_i = 8'h96;
	int          err_count = 0;
	int          cmp_count = 0;
	// Writes carry d, reads expect x; a is the low address byte
	row_type rows [25] = '{
		'{0, 8'hc0, 0, 16'h3c5a}, '{1, 8'hc4, 16'hffff, 0}, '{0, 8'hc0, 0, 16'h0000},
		'{1, 8'hc4, 16'h0000, 0}, '{1, 8'hc0, 16'h1234, 0}, '{0, 8'hc0, 0, 16'h3c5a},
		'{1, 8'hc4, 16'h00ff, 0}, '{0, 8'hc0, 0, 16'h3c34}, '{1, 8'he4, 16'h000f, 0},
		'{1, 8'he2, 16'h00f0, 0}, '{1, 8'hc6, 16'hffff, 0}, '{1, 8'hc2, 16'hffff, 0},
		'{0, 8'hc2, 0, 16'hfff0}, '{1, 8'hd0, 16'hffff, 0}, '{0, 8'hd0, 0, 16'h0096},
		'{1, 8'he6, 16'h0003, 0}, '{0, 8'hd0, 0, 16'h0097}, '{0, 8'hc8, 0, 16'h0000},
		'{1, 8'he0, 16'h0f00, 0}, '{1, 8'hc4, 16'hffff, 0}, '{0, 8'hc4, 0, 16'hffff},
		'{0, 8'hc0, 0, 16'h1234}, '{1, 8'hc6, 16'h0f0f, 0}, '{0, 8'hc6, 0, 16'h0f0f},
		'{0, 8'hc2, 0, 16'hafc0}};
	port_data_registers u_dut (.ref_clk_i, .reset_i, .addr_i, .wdata_i, .write_i, .read_i,
		.rdata_o, .first_pin_i, .first_pin_o, .first_pin_oe_o, .second_pin_i, .second_pin_o,
		.second_pin_oe_o, .third_pin_i);
	pin_partner u_pin_a (.out_i(first_pin_o), .oe_i(first_pin_oe_o), .ext_i(16'h3c5a), .pin_o(first_pin_i));
	pin_partner u_pin_b (.out_i(second_pin_o), .oe_i(second_pin_oe_o), .ext_i(16'ha5c3), .pin_o(second_pin_i));
	// Prints the counts and the verdict, then stops
	task automatic end_sim;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Clock and hang guard
	initial forever #2 ref_clk_i = ~ref_clk_i;
	initial begin
		repeat (400) @(posedge ref_clk_i);
		err_count++;
		end_sim;
	end
	// Table walk, then pin state and a second reset
	initial begin
		repeat (16) @(posedge ref_clk_i);
		reset_i <= 0;
		foreach (rows[i]) begin
			@(posedge ref_clk_i);
			write_i <= rows[i].wr;
			read_i  <= !rows[i].wr;
			addr_i  <= {20'h5_ffff, rows[i].a};
			wdata_i <= rows[i].d;
			@(posedge ref_clk_i);
			write_i <= 0;
			read_i  <= 0;
			#1;
			if (!rows[i].wr) `CHK(rdata_o, rows[i].x)
		end
		$display("table test done");
		`CHK(first_pin_i, 16'h1c34)
		`CHK(first_pin_oe_o, 16'hf0ff)
		`CHK(second_pin_oe_o, 16'h0f00)
		`CHK(second_pin_o & second_pin_oe_o, 16'h0f00)
		$display("pin test done");
		// Write, read, read with no idle cycle between the strobes
		@(posedge ref_clk_i);
		write_i <= 1;
		addr_i  <= {20'h5_ffff, 8'hc4};
		wdata_i <= 16'h00ff;
		@(posedge ref_clk_i);
		write_i <= 0;
		read_i  <= 1;
		@(posedge ref_clk_i);
		addr_i  <= {20'h5_ffff, 8'hd0};
		#1;
		`CHK(rdata_o, 16'h00ff)
		@(posedge ref_clk_i);
		read_i  <= 0;
		#1;
		`CHK(rdata_o, 16'h0097)
		@(posedge ref_clk_i);
		#1;
		`CHK(rdata_o, 16'h0000)
		$display("back-to-back test done");
		// Mid-run reset, with a read taken at the first edge after release
		@(posedge ref_clk_i);
		reset_i <= 1;
		@(posedge ref_clk_i);
		reset_i <= 0;
		read_i  <= 1;
		addr_i  <= {20'h5_ffff, 8'hc0};
		#1;
		`CHK(first_pin_oe_o | second_pin_o, 16'h0000)
		@(posedge ref_clk_i);
		read_i  <= 0;
		write_i <= 1;
		addr_i  <= {20'h5_ffff, 8'hc4};
		wdata_i <= 16'hffff;
		#1;
		`CHK(rdata_o, 16'h3c5a)
		@(posedge ref_clk_i);
		write_i <= 0;
		read_i  <= 1;
		addr_i  <= {20'h5_ffff, 8'hc0};
		@(posedge ref_clk_i);
		read_i  <= 0;
		#1;
		`CHK(rdata_o, 16'h0000)
		$display("reset test done");
		end_sim;
	end
endmodule
